/* hdl/pin_mux_pkg.sv */
// Behaviour
// R1 - usart0 clock pin drives when direction bit set, receives when clear
// R2 - usart0 clock pin acts only in synchronous usart mode
// R3 - port b bit 0 feeds pin change source 8 and timer0 count input
// R4 - spi data overrides built from master and slave halves per pin
// R5 - port c bit 7 is timer osc pin two and pin change source 23
// R6 - port c bit 6 is timer osc pin one and pin change source 22
// R7 - port c bit 5 is jtag data in and pin change source 21
// R8 - port c bit 4 is jtag data out and pin change source 20
// R9 - port c bit 3 is jtag mode select and pin change source 19
// R10 - port c bit 2 is jtag clock and pin change source 18
// R11 - port c bit 1 is two-wire data line and pin change source 17
// R12 - port c bit 0 is two-wire clock line and pin change source 16
// R13 - spi slave forces clock pin input, pull-up from port bit and disable
// R14 - port b pin input enabled only with mask bit and group enable
package pin_mux_pkg;
   localparam int PB_WIDTH  = 8;
   localparam int PC_WIDTH  = 8;
   localparam int PB_SCK    = 7;
   localparam int PB_MISO   = 6;
   localparam int PB_MOSI   = 5;
   localparam int PB_XCK    = 0;
   localparam int PC_OSC_TWO = 7;
   localparam int PC_OSC_ONE = 6;
   localparam int PC_TDI    = 5;
   localparam int PC_TDO    = 4;
   localparam int PC_TMS    = 3;
   localparam int PC_TCK    = 2;
   localparam int PC_SDA    = 1;
   localparam int PC_SCL    = 0;
   localparam logic [7:0] PIN_RESET = 8'h00;

   // per-port override bundle, one bit per pin
   typedef struct packed {
      logic [7:0] pull_en;    // pull-up override enable
      logic [7:0] pull_val;   // pull-up override value
      logic [7:0] dir_en;     // direction override enable
      logic [7:0] dir_val;    // direction override value
      logic [7:0] drv_en;     // port value override enable
      logic [7:0] drv_val;    // port value override value
      logic [7:0] din_en;     // digital input enable
   } port_ovr_t;

   typedef struct packed {
      logic spi_unit_enable;
      logic spi_master_select;
      logic spi_master_out;
      logic spi_slave_out;
      logic spi_clock_out;
   } spi_ctl_t;

   typedef struct packed {
      logic jtag_enable;
      logic jtag_shift;      // shift ir or shift dr active
      logic jtag_data_out;
      logic twi_enable;
      logic twi_sda_out;
      logic twi_scl_out;
      logic async_timer;     // timer2 on its own oscillator
      logic ext_clock;       // external clock on oscillator pin
   } portc_ctl_t;
endpackage

/* hdl/port_b_c_alt_function_mux.sv */
module port_b_c_alt_function_mux (
   input  wire logic                    clk,          // system clock
   input  wire logic                    rstn,         // async reset, low
   input  wire logic [7:0]              portb_out,    // port b data bits
   input  wire logic [7:0]              portb_dir,    // port b direction
   input  wire logic [7:0]              portc_out,    // port c data bits
   input  wire logic [7:0]              pb_pin,       // port b pin levels
   input  wire logic [7:0]              pc_pin,       // port c pin levels
   input  wire logic                    global_pullup_disable, // pull-ups off
   input  wire logic                    usart0_sync_mode, // usart0 sync
   input  wire logic                    usart0_clk_out, // usart0 clock out
   input  wire logic [7:0]              portb_pc_mask, // pin change masks
   input  wire logic [7:0]              portc_pc_mask, // pin change masks
   input  wire logic                    portb_pin_change_group_enable, // grp
   input  wire logic                    portc_pc_group_enable, // group
   input  wire pin_mux_pkg::spi_ctl_t   spi_ctl,      // spi controls
   input  wire pin_mux_pkg::portc_ctl_t pc_ctl,       // port c controls
   output      pin_mux_pkg::port_ovr_t  pb_ovr,       // port b overrides
   output      pin_mux_pkg::port_ovr_t  pc_ovr,       // port c overrides
   output      logic [7:0]              pb_pc_src,    // sources 8..15
   output      logic [7:0]              pc_pc_src,    // sources 16..23
   output      logic                    timer0_count_input, // counter pin
   output      logic                    usart0_clk_in, // usart0 clock in
   output      logic                    usart0_ext_clock_pin_oe, // drive
   output      logic                    usart0_ext_clock_pin_o, // level
   output      logic                    spi_master_in, // spi master input
   output      logic                    spi_slave_in, // spi slave input
   output      logic                    spi_clock_in, // spi clock input
   output      logic                    jtag_tdi,     // test data in
   output      logic                    jtag_tms,     // test mode select
   output      logic                    jtag_tck,     // test clock
   output      logic                    twi_sda_in,   // two-wire data in
   output      logic                    twi_scl_in,   // two-wire clock in
   output      logic                    timer_osc_pin_one, // osc input
   output      logic                    timer_osc_pin_two  // osc output side
);
   import pin_mux_pkg::*;

   // pins are asynchronous: two flops before anything reads them
   logic [7:0] pb_s1_q, pb_s2_q, pc_s1_q, pc_s2_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pb_s1_q <= PIN_RESET;
         pb_s2_q <= PIN_RESET;
         pc_s1_q <= PIN_RESET;
         pc_s2_q <= PIN_RESET;
      end else begin
         pb_s1_q <= pb_pin;
         pb_s2_q <= pb_s1_q;
         pc_s1_q <= pc_pin;
         pc_s2_q <= pc_s1_q;
      end
   end

   logic spi_slave, spi_master;
   assign spi_slave  = spi_ctl.spi_unit_enable & ~spi_ctl.spi_master_select;
   assign spi_master = spi_ctl.spi_unit_enable & spi_ctl.spi_master_select;

   port_ovr_t pb_d, pc_d;
   logic      pull_ok_b7;
   assign pull_ok_b7 = ~global_pullup_disable;

   always_comb begin
      pb_d = '0;
      // R13 slave clock pin
      pb_d.pull_en[PB_SCK]  = spi_slave;
      pb_d.pull_val[PB_SCK] = portb_out[PB_SCK] & pull_ok_b7;
      pb_d.dir_en[PB_SCK]   = spi_slave;
      pb_d.drv_en[PB_SCK]   = spi_master;
      pb_d.drv_val[PB_SCK]  = spi_ctl.spi_clock_out;
      // R4 data pin halves
      pb_d.pull_en[PB_MISO]  = spi_master;
      pb_d.pull_val[PB_MISO] = portb_out[PB_MISO] & pull_ok_b7;
      pb_d.dir_en[PB_MISO]   = spi_master;
      pb_d.drv_en[PB_MISO]   = spi_slave;
      pb_d.drv_val[PB_MISO]  = spi_ctl.spi_slave_out;
      pb_d.pull_en[PB_MOSI]  = spi_slave;
      pb_d.pull_val[PB_MOSI] = portb_out[PB_MOSI] & pull_ok_b7;
      pb_d.dir_en[PB_MOSI]   = spi_slave;
      pb_d.drv_en[PB_MOSI]   = spi_master;
      pb_d.drv_val[PB_MOSI]  = spi_ctl.spi_master_out;
      // R1 R2 usart clock direction in sync mode only
      pb_d.drv_en[PB_XCK]  = usart0_sync_mode & portb_dir[PB_XCK];
      pb_d.drv_val[PB_XCK] = usart0_clk_out;
      // R14 input enable per mask and group enable
      pb_d.din_en = portb_pc_mask & {PB_WIDTH{portb_pin_change_group_enable}};
   end

   always_comb begin
      pc_d = '0;
      // R5 R6 oscillator pins
      pc_d.pull_en[PC_OSC_TWO] = pc_ctl.async_timer & pc_ctl.ext_clock;
      pc_d.dir_en[PC_OSC_TWO]  = pc_ctl.async_timer & pc_ctl.ext_clock;
      pc_d.din_en[PC_OSC_TWO]  = ~(pc_ctl.async_timer & pc_ctl.ext_clock) &
                                 (~portc_pc_mask[PC_OSC_TWO] |
                                  portc_pc_group_enable);
      pc_d.pull_en[PC_OSC_ONE] = pc_ctl.async_timer;
      pc_d.dir_en[PC_OSC_ONE]  = pc_ctl.async_timer;
      pc_d.din_en[PC_OSC_ONE]  = pc_ctl.async_timer ? pc_ctl.ext_clock : 1'b1;
      // R7 R8 R9 R10 jtag pins, pull-ups on, tdo driven while shifting
      pc_d.pull_en[PC_TDI:PC_TCK]  = {4{pc_ctl.jtag_enable}};
      pc_d.pull_val[PC_TDI:PC_TCK] = 4'hf;
      pc_d.dir_en[PC_TDI:PC_TCK]   = {4{pc_ctl.jtag_enable}};
      pc_d.dir_val[PC_TDO]         = pc_ctl.jtag_shift;
      pc_d.drv_en[PC_TDO]          = pc_ctl.jtag_enable;
      pc_d.drv_val[PC_TDO]         = pc_ctl.jtag_data_out;
      pc_d.din_en[PC_TDI:PC_TCK]   = {4{~pc_ctl.jtag_enable}};
      // R11 R12 two-wire lines
      pc_d.pull_en[PC_SDA:PC_SCL]  = {2{pc_ctl.twi_enable}};
      pc_d.pull_val[PC_SDA:PC_SCL] = portc_out[PC_SDA:PC_SCL] &
                                     {2{~global_pullup_disable}};
      pc_d.dir_en[PC_SDA:PC_SCL]   = {2{pc_ctl.twi_enable}};
      pc_d.drv_en[PC_SDA:PC_SCL]   = {2{pc_ctl.twi_enable}};
      pc_d.drv_val[PC_SDA]         = pc_ctl.twi_sda_out;
      pc_d.drv_val[PC_SCL]         = pc_ctl.twi_scl_out;
      pc_d.din_en[PC_SDA:PC_SCL]   = 2'h3;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pb_ovr <= '0;
         pc_ovr <= '0;
      end else begin
         pb_ovr <= pb_d;
         pc_ovr <= pc_d;
      end
   end

   // the usart clock pin: drive when direction bit set, else receive
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         usart0_ext_clock_pin_oe <= 1'b0;
         usart0_ext_clock_pin_o  <= 1'b0;
         usart0_clk_in           <= 1'b0;
      end else begin
         // R1 direction follows bit
         usart0_ext_clock_pin_oe <= usart0_sync_mode & portb_dir[PB_XCK];
         usart0_ext_clock_pin_o  <= usart0_sync_mode & portb_dir[PB_XCK] &
                                    usart0_clk_out;
         // R2 only in sync mode
         usart0_clk_in <= usart0_sync_mode & ~portb_dir[PB_XCK] &
                          pb_s2_q[PB_XCK];
      end
   end

   // pin inputs to peripherals and pin-change sources
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pb_pc_src          <= PIN_RESET;
         pc_pc_src          <= PIN_RESET;
         timer0_count_input <= 1'b0;
         spi_master_in      <= 1'b0;
         spi_slave_in       <= 1'b0;
         spi_clock_in       <= 1'b0;
      end else begin
         // R3 source 8 and timer0
         pb_pc_src          <= pb_s2_q & pb_d.din_en;
         timer0_count_input <= pb_s2_q[PB_XCK];
         // R4 opposite-side data inputs
         spi_master_in <= pb_s2_q[PB_MISO];
         spi_slave_in  <= pb_s2_q[PB_MOSI];
         spi_clock_in  <= pb_s2_q[PB_SCK];
         // R5 R12 port c sources 16..23
         pc_pc_src <= pc_s2_q & portc_pc_mask &
                      {PC_WIDTH{portc_pc_group_enable}};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         jtag_tdi          <= 1'b0;
         jtag_tms          <= 1'b0;
         jtag_tck          <= 1'b0;
         twi_sda_in        <= 1'b0;
         twi_scl_in        <= 1'b0;
         timer_osc_pin_one <= 1'b0;
         timer_osc_pin_two <= 1'b0;
      end else begin
         // R7 R9 R10 jtag inputs
         jtag_tdi <= pc_s2_q[PC_TDI];
         jtag_tms <= pc_s2_q[PC_TMS];
         jtag_tck <= pc_s2_q[PC_TCK];
         // R11 R12 two-wire inputs
         twi_sda_in <= pc_s2_q[PC_SDA];
         twi_scl_in <= pc_s2_q[PC_SCL];
         // R6 R5 oscillator pins as seen by the timer
         timer_osc_pin_one <= pc_s2_q[PC_OSC_ONE];
         timer_osc_pin_two <= pc_s2_q[PC_OSC_TWO];
      end
   end

   // assertions; the release edge still shows reset values, so checks that
   // expect a driven override start one edge later via the past reset level
   // R1 direction follows bit
   a_xck_dir_follow: assert property (@(posedge clk) disable iff (!rstn) // R1
      $past(rstn) && usart0_sync_mode |=>
         usart0_ext_clock_pin_oe == $past(portb_dir[PB_XCK]))
      else $error("usart clock pin direction wrong");
   // R2 sync mode only
   a_xck_async_off: assert property (@(posedge clk) disable iff (!rstn) // R2
      !usart0_sync_mode |=> !usart0_ext_clock_pin_oe && !usart0_clk_in)
      else $error("usart clock pin active outside sync mode");
   // R3 counter pin path
   a_timer0_pin_path: assert property (@(posedge clk) disable iff (!rstn) // R3
      $rose(pb_pin[PB_XCK]) ##1 pb_pin[PB_XCK] ##1 pb_pin[PB_XCK] |=>
         timer0_count_input)
      else $error("timer0 input missed pin level");
   // R4 master data halves
   a_spi_master_data: assert property (@(posedge clk) disable iff (!rstn) // R4
      $past(rstn) && spi_master |=>
         pb_ovr.drv_en[PB_MOSI] && !pb_ovr.drv_en[PB_MISO] &&
         pb_ovr.drv_val[PB_MOSI] == $past(spi_ctl.spi_master_out))
      else $error("spi master data override wrong");
   // R8 test data out
   a_tdo_drive: assert property (@(posedge clk) disable iff (!rstn) // R8
      $past(rstn) && pc_ctl.jtag_enable |=> pc_ovr.drv_en[PC_TDO] &&
         pc_ovr.drv_val[PC_TDO] == $past(pc_ctl.jtag_data_out))
      else $error("jtag data out not driven");
   // R11 R12 two-wire lines
   a_twi_lines: assert property (@(posedge clk) disable iff (!rstn) // R11 R12
      $past(rstn) && pc_ctl.twi_enable |=>
         pc_ovr.drv_en[PC_SDA:PC_SCL] == 2'h3)
      else $error("two-wire lines not overridden");
   // R13 slave clock input
   a_sck_slave_in: assert property (@(posedge clk) disable iff (!rstn) // R13
      $past(rstn) && spi_slave |=>
         pb_ovr.dir_en[PB_SCK] && !pb_ovr.dir_val[PB_SCK] &&
         pb_ovr.pull_val[PB_SCK] ==
            $past(portb_out[PB_SCK] & ~global_pullup_disable))
      else $error("spi clock pin not forced input");
   // R14 group enable gate
   a_pc_src_gate: assert property (@(posedge clk) disable iff (!rstn) // R14
      !portb_pin_change_group_enable |=> pb_pc_src == PIN_RESET)
      else $error("pin change source passed without group enable");
   c_spi_slave: cover property (@(posedge clk) disable iff (!rstn) spi_slave);
   c_xck_out: cover property (@(posedge clk) disable iff (!rstn)
      usart0_ext_clock_pin_oe);
   c_jtag_on: cover property (@(posedge clk) disable iff (!rstn)
      pc_ctl.jtag_enable && pc_ctl.jtag_shift);
endmodule

/* verif/pin_partner.sv */
module pin_partner #(
   parameter int SEED = 27132
) (
   input  wire logic       clk,    // system clock
   input  wire logic       xck_oe, // device drives the usart clock pin
   input  wire logic       xck_o,  // level the device drives
   output      logic [7:0] pb_pin, // port b pin levels
   output      logic [7:0] pc_pin  // port c pin levels
);
   timeunit 1ns;
   timeprecision 1ps;
   integer     seed   = SEED;
   logic [7:0] pb_ext = 8'h00;
   logic [7:0] pc_ext = 8'h00;

   // far side takes a new random value every cycle so a latency slip cannot hide
   always @(posedge clk) begin
      pb_ext <= 8'($random(seed));
      pc_ext <= 8'($random(seed));
   end

   // pin follows the device clock while driven
   assign pb_pin = {pb_ext[7:1], xck_oe ? xck_o : pb_ext[0]};
   assign pc_pin = pc_ext;
endmodule

/* verif/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pin_mux_pkg::*;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic [7:0] portb_out = 8'h00, portb_dir = 8'h00, portc_out = 8'h00;
   logic [7:0] pb_mask = 8'h00, pc_mask = 8'h00, pb_pin, pc_pin;
   logic       pullup_off = 1'b0, sync = 1'b0, xck_drv = 1'b0;
   logic       pb_grp = 1'b0, pc_grp = 1'b0;
   spi_ctl_t   spi = '0;
   portc_ctl_t pcc = '0;
   port_ovr_t  pb_ovr, pc_ovr;
   logic [7:0] pb_src, pc_src, pbh [0:2], pch [0:2];
   logic       timer0_in, xck_in, xck_oe, xck_o, m_in, s_in, sck_in;
   logic       tdi, tms, tck, sda_in, scl_in, osc1, osc2, sl, ms, tw, je;
   logic [31:0] r1, r2;
   logic [7:0] pe, sm;
   integer     seed = 27132;
   integer     failures = 0, n_compared = 0, stable = 0;

   always #4 clk = ~clk;

   port_b_c_alt_function_mux uut (.clk(clk), .rstn(rstn),
      .portb_out(portb_out), .portb_dir(portb_dir), .portc_out(portc_out),
      .pb_pin(pb_pin), .pc_pin(pc_pin), .global_pullup_disable(pullup_off),
      .usart0_sync_mode(sync), .usart0_clk_out(xck_drv),
      .portb_pc_mask(pb_mask), .portc_pc_mask(pc_mask),
      .portb_pin_change_group_enable(pb_grp), .portc_pc_group_enable(pc_grp),
      .spi_ctl(spi), .pc_ctl(pcc), .pb_ovr(pb_ovr), .pc_ovr(pc_ovr),
      .pb_pc_src(pb_src), .pc_pc_src(pc_src), .timer0_count_input(timer0_in),
      .usart0_clk_in(xck_in), .usart0_ext_clock_pin_oe(xck_oe),
      .usart0_ext_clock_pin_o(xck_o), .spi_master_in(m_in),
      .spi_slave_in(s_in), .spi_clock_in(sck_in), .jtag_tdi(tdi),
      .jtag_tms(tms), .jtag_tck(tck), .twi_sda_in(sda_in),
      .twi_scl_in(scl_in), .timer_osc_pin_one(osc1),
      .timer_osc_pin_two(osc2));

   pin_partner #(.SEED(27132)) far (.clk(clk), .xck_oe(xck_oe),
      .xck_o(xck_o), .pb_pin(pb_pin), .pc_pin(pc_pin));

   task automatic check(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
                  exp);
      end
   endtask

   task automatic finish_test;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // inputs hold 8 cycles so pin checks can see a settled control set
   always @(posedge clk) begin
      pbh[2] <= pbh[1];
      pbh[1] <= pbh[0];
      pbh[0] <= pb_pin;
      pch[2] <= pch[1];
      pch[1] <= pch[0];
      pch[0] <= pc_pin;
      if (!rstn) begin
         stable <= 0;
      end else if (stable == 7) begin
         r1 = $random(seed);
         r2 = $random(seed);
         {portb_out, portb_dir, portc_out, pb_mask} <= r1;
         pc_mask <= r2[7:0];
         {pullup_off, sync, xck_drv, pb_grp, pc_grp} <= r2[12:8];
         spi <= spi_ctl_t'(r2[17:13]);
         pcc <= portc_ctl_t'(r2[25:18]);
         stable <= 0;
      end else begin
         stable <= stable + 1;
      end
   end

   always @(negedge clk) begin
      sl = spi.spi_unit_enable & ~spi.spi_master_select;
      ms = spi.spi_unit_enable & spi.spi_master_select;
      tw = pcc.twi_enable;
      je = pcc.jtag_enable;
      sm = {sl, ms, sl, 5'h0};
      pe = {pcc.async_timer & pcc.ext_clock, pcc.async_timer, {4{je}},
            tw, tw};
      if (!rstn) begin
         check(pb_ovr.dir_en | pb_src | pc_src, 8'h00, "reset outputs");
      end else if (stable >= 1) begin
         check({pb_ovr.dir_en[7], pb_ovr.dir_val[7], pb_ovr.pull_en[7],
                pb_ovr.pull_val[7] & sl, 4'h0},
               {sl, 1'b0, sl, sl & portb_out[7] & ~pullup_off, 4'h0},
               "sck");
         check(pb_ovr.dir_en, sm, "pb dir_en");
         check(pb_ovr.pull_en, sm, "pb pull_en");
         check(pb_ovr.dir_val, 8'h00, "pb dir_val");
         check(pb_ovr.pull_val & sm, portb_out & sm & {8{~pullup_off}},
               "pb pull_val");
         check(pb_ovr.drv_en, {ms, sl, ms, 4'h0, sync & portb_dir[0]},
               "pb drv_en");
         check(pb_ovr.drv_val & pb_ovr.drv_en,
               {ms & spi.spi_clock_out, sl & spi.spi_slave_out,
                ms & spi.spi_master_out, 4'h0,
                sync & portb_dir[0] & xck_drv}, "pb drv_val");
         check(pc_ovr.dir_en, pe, "pc dir_en");
         check(pc_ovr.pull_en, pe, "pc pull_en");
         check(pc_ovr.pull_val & pe,
               {2'h0, 4'hf, portc_out[1:0] & {2{~pullup_off}}} & pe,
               "pc pull_val");
         check(pc_ovr.dir_val & pc_ovr.dir_en,
               {3'h0, je & pcc.jtag_shift, 4'h0}, "pc dir_val");
         check({4'h0, pb_ovr.drv_en[6], pb_ovr.drv_val[6] & pb_ovr.drv_en[6],
                pb_ovr.drv_en[5], pb_ovr.drv_val[5] & pb_ovr.drv_en[5]},
               {4'h0, sl, sl & spi.spi_slave_out, ms,
                ms & spi.spi_master_out}, "spi data drive");
         check(pb_ovr.din_en, pb_mask & {8{pb_grp}}, "pb din_en");
         check({pc_ovr.drv_en[4], pc_ovr.drv_val[4] & pc_ovr.drv_en[4],
                pc_ovr.drv_en[1:0], pc_ovr.drv_val[1:0] & pc_ovr.drv_en[1:0],
                2'h0},
               {je, je & pcc.jtag_data_out, tw, tw, tw & pcc.twi_sda_out,
                tw & pcc.twi_scl_out, 2'h0}, "pc drive");
         check({6'h0, xck_oe, xck_o & xck_oe},
               {6'h0, sync & portb_dir[0], sync & portb_dir[0] & xck_drv},
               "usart clock drive");
      end
      if (rstn && stable >= 4) begin
         check({sck_in, m_in, s_in, 4'h0, timer0_in}, pbh[2] & 8'he1,
               "pb inputs");
         check(pb_src, pbh[2] & pb_mask & {8{pb_grp}}, "pb src");
         check({osc2, osc1, tdi, 1'b0, tms, tck, sda_in, scl_in},
               pch[2] & 8'hef, "pc inputs");
         check(pc_src, pch[2] & pc_mask & {8{pc_grp}}, "pc src");
         if (sync && !portb_dir[0])
            check({7'h0, xck_in}, {7'h0, pbh[2][0]}, "usart clock in");
      end
   end

   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (1500) @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (1500) @(posedge clk);
      finish_test();
   end
endmodule
